// ==== logic/dee_pkg.sv ====
// Constants and types shared by the data EEPROM access control block
package deac_pkg;

	// ==========================================================
	// Control register location, reached through indirect access
	localparam logic [7:0] CTRL_ADDR = 8'h40;
	localparam logic [7:0] CTRL_BANK = 8'h01;

	// ==========================================================
	// Control register field positions and register reset values
	localparam int RD_START_BIT = 0;
	localparam int RD_EN_BIT = 1;
	localparam int WR_START_BIT = 2;
	localparam int WR_EN_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [7:0] DATA_REG_RESET = 8'h00;
	localparam logic [7:0] ADDR_REG_RESET = 8'h00;

	// ==========================================================
	// Array geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DEPTH = 256;

	// ==========================================================
	// Timing: least times, rounded up to whole 4 ns cycles
	localparam int CLK_PERIOD_PS = 4000;
	localparam int WRITE_TIME_NS = 2000;
	localparam int READ_TIME_NS = 8;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_CYCLES = (READ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W = 16;

	// ==========================================================
	// Access sequencer states
	typedef enum logic [2:0]
	{
		DEAC_IDLE = 3'b001,
		DEAC_READ = 3'b010,
		DEAC_WRITE = 3'b100
	} deac_state_e;

endpackage

// ==== logic/dee_mem.sv ====
// Data EEPROM storage array with registered read data
`timescale 1ns/1ps
module deac_mem
(
	// Clock
	input wire logic sys_clk_i,
	// Write port
	input wire logic we_i,
	input wire logic [deac_pkg::ADDR_W-1:0] waddr_i,
	input wire logic [deac_pkg::DATA_W-1:0] wdata_i,
	// Read port
	input wire logic [deac_pkg::ADDR_W-1:0] raddr_i,
	output logic [deac_pkg::DATA_W-1:0] rdata_o
);
	import deac_pkg::*;

	logic [DATA_W-1:0] cells [DEPTH];

	// Array write and registered read
	always_ff @(posedge sys_clk_i)
	begin
		if (we_i)
		begin
			cells[waddr_i] <= wdata_i;
		end
		rdata_o <= cells[raddr_i];
	end

endmodule // deac_mem

// ==== logic/dee_access_ctrl.sv ====
// Data EEPROM access control: banked control register, read/write sequencer
//
// Contract
// [R01] Software sets write start in the instruction right after setting write enable.
// [R02] Software masks interrupts around the write unlock and start.
// [R03] A cycle running when idle or sleep mode is entered fails.
// [R04] Control register reachable only with bank pointer selecting bank 1.
// [R06] Control register is reached indirectly at pointer 040H, bank 01H.
// [R05] Software keeps write enable cleared except while writing.
// [R07] Bit 1 read enable, bit 0 read start; together they launch a read.
// [R08] Read start stays high during the read and clears when done.
// [R09] Bit 3 write enable, bit 2 write start; they launch a write of data.
// [R10] Write start stays high for the whole write and clears at its end.
// [R11] Writing zero to the control register clears both enables.
// [R12] Software may read a written location back to verify it.
// [R13] A start bit set while its enable is clear has no effect.
// [R14] After reset all four control bits are zero.
// [R15] Cycle end sets request flag and multi-function flag; only the latter auto-clears.
// [R16] Read and write starts requested together are both refused.
`timescale 1ns/1ps
module deac_access_ctrl
#(
	parameter int WRITE_COUNT = deac_pkg::WRITE_CYCLES
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Indirect access to the control register
	input wire logic [7:0] mem_ptr_i,
	input wire logic [7:0] bank_ptr_i,
	input wire logic ind_wr_i,
	input wire logic [7:0] ind_wdata_i,
	output logic [7:0] ind_rdata_o,
	// Direct address and data registers
	input wire logic addr_wr_i,
	input wire logic data_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] eeprom_address_o,
	output logic [7:0] eeprom_data_o,
	// Power mode and interrupt flags
	input wire logic low_power_i,
	input wire logic req_flag_clr_i,
	input wire logic mf_flag_ack_i,
	output logic eeprom_request_flag_o,
	output logic mf_request_flag_o,
	output logic busy_o
);
	import deac_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_meta;
	logic rst_n;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// Decode and launch conditions
	deac_state_e state;
	deac_state_e next_state;
	logic [TMR_W-1:0] timer;
	logic [TMR_W-1:0] next_timer;
	logic rd_en;
	logic wr_en;
	logic rd_go;
	logic wr_go;
	logic [7:0] ee_addr;
	logic [7:0] ee_data;
	logic req_flag;
	logic mf_flag;
	logic [DATA_W-1:0] mem_rdata;
	wire ctrl_sel;
	wire ctrl_wr;
	wire both_req;
	wire launch_rd;
	wire launch_wr;
	wire tmr_last;
	wire finish_rd;
	wire finish_wr;
	wire abort;
	wire [7:0] ctrl_view;

	assign ctrl_sel = (bank_ptr_i == CTRL_BANK) && (mem_ptr_i == CTRL_ADDR); // R04 R06
	assign ctrl_wr = ind_wr_i && ctrl_sel; // R04
	assign both_req = ind_wdata_i[RD_START_BIT] && ind_wdata_i[WR_START_BIT]; // R16
	// Start needs the enable already set before this write
	assign launch_rd = ctrl_wr && ind_wdata_i[RD_START_BIT] && rd_en && !both_req
		&& (state == DEAC_IDLE) && !low_power_i; // R07 R13
	assign launch_wr = ctrl_wr && ind_wdata_i[WR_START_BIT] && wr_en && !both_req
		&& (state == DEAC_IDLE) && !low_power_i; // R09 R13
	assign tmr_last = (timer == TMR_W'(1));
	assign abort = low_power_i && (state != DEAC_IDLE); // R03
	assign finish_rd = (state == DEAC_READ) && tmr_last && !low_power_i;
	assign finish_wr = (state == DEAC_WRITE) && tmr_last && !low_power_i;
	assign ctrl_view = {4'h0, wr_en, wr_go, rd_en, rd_go};

	// ==========================================================
	// Sequencer next state and cycle timer
	always_comb
	begin
		next_state = state;
		next_timer = timer;
		unique case (state)
			DEAC_IDLE:
			begin
				if (launch_rd)
				begin
					next_state = DEAC_READ;
					next_timer = TMR_W'(READ_CYCLES);
				end
				else if (launch_wr)
				begin
					next_state = DEAC_WRITE;
					next_timer = TMR_W'(WRITE_COUNT);
				end
			end
			DEAC_READ, DEAC_WRITE:
			begin
				next_timer = timer - TMR_W'(1);
				if (abort || tmr_last)
				begin
					next_state = DEAC_IDLE; // R03
					next_timer = '0;
				end
			end
			default:
			begin
				next_state = DEAC_IDLE;
				next_timer = '0;
			end
		endcase
	end

	// State and timer registers
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= DEAC_IDLE;
			timer <= '0;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// ==========================================================
	// Control bits: enables follow software, starts are hardware-cleared
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{wr_en, wr_go, rd_en, rd_go} <= CTRL_RESET; // R14
		end
		else
		begin
			if (ctrl_wr)
			begin
				rd_en <= ind_wdata_i[RD_EN_BIT]; // R11
				wr_en <= ind_wdata_i[WR_EN_BIT]; // R11
			end
			rd_go <= launch_rd || (rd_go && !finish_rd && !abort); // R08
			wr_go <= launch_wr || (wr_go && !finish_wr && !abort); // R10
		end
	end

	// Address and data registers; software writes refused while busy
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ee_addr <= ADDR_REG_RESET;
			ee_data <= DATA_REG_RESET;
		end
		else
		begin
			if (addr_wr_i && (state == DEAC_IDLE))
			begin
				ee_addr <= sfr_wdata_i;
			end
			if (finish_rd)
			begin
				ee_data <= mem_rdata; // R07
			end
			else if (data_wr_i && (state == DEAC_IDLE))
			begin
				ee_data <= sfr_wdata_i;
			end
		end
	end

	// End-of-cycle flags; a new end wins over a same-cycle clear
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_flag <= 1'b0;
			mf_flag <= 1'b0;
		end
		else
		begin
			req_flag <= finish_rd || finish_wr || (req_flag && !req_flag_clr_i); // R15
			mf_flag <= finish_rd || finish_wr || (mf_flag && !mf_flag_ack_i); // R15
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ind_rdata_o <= 8'h00;
			busy_o <= 1'b0;
		end
		else
		begin
			ind_rdata_o <= ctrl_sel ? ctrl_view : 8'h00; // R04
			busy_o <= (next_state != DEAC_IDLE);
		end
	end

	assign eeprom_address_o = ee_addr;
	assign eeprom_data_o = ee_data;
	assign eeprom_request_flag_o = req_flag;
	assign mf_request_flag_o = mf_flag;

	// ==========================================================
	// Storage array; write commits only at the end of a full write
	deac_mem u_mem
	(
		.sys_clk_i(sys_clk_i),
		.we_i(finish_wr), // R09 R03
		.waddr_i(ee_addr),
		.wdata_i(ee_data),
		.raddr_i(ee_addr),
		.rdata_o(mem_rdata)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	a_bank_gate: assert property (ind_wr_i && !ctrl_sel |=> $stable({rd_en, wr_en})) // R04
		else $error("control bits changed without bank 1 select");
	a_wr_need_en: assert property (ctrl_wr && ind_wdata_i[WR_START_BIT] && !wr_en && !wr_go // R13
		|=> !wr_go) else $error("write started without enable");
	a_rd_need_en: assert property (ctrl_wr && ind_wdata_i[RD_START_BIT] && !rd_en && !rd_go // R13
		|=> !rd_go) else $error("read started without enable");
	a_wr_cycle_end: assert property (launch_wr |=> wr_go ##[1:600] !wr_go) // R10
		else $error("write start did not clear in time");
	a_rd_cycle_len: assert property (launch_rd ##1 !low_power_i ##1 !low_power_i // R08
		|-> rd_go ##1 !rd_go) else $error("read start length wrong");
	a_flag_set: assert property (finish_rd || finish_wr |=> req_flag && mf_flag) // R15
		else $error("cycle end did not raise flags");
	a_zero_clear: assert property (ctrl_wr && ind_wdata_i == 8'h00 |=> !rd_en && !wr_en) // R11
		else $error("zero write left an enable set");
	a_no_both: assert property (ctrl_wr && both_req && state == DEAC_IDLE // R16
		|=> state == DEAC_IDLE) else $error("joint start request accepted");
	a_lp_abort: assert property (abort |=> state == DEAC_IDLE && !$rose(req_flag)) // R03
		else $error("cycle survived low-power entry");
	a_read_data: assert property (finish_rd |=> ee_data == $past(mem_rdata)) // R07
		else $error("read data not loaded");
	a_reset_zero: assert property (@(posedge sys_clk_i) disable iff (1'b0) // R14
		$rose(rst_n) |-> ctrl_view == 8'h00) else $error("control bits not zero after reset");

endmodule // deac_access_ctrl

// ==== bench/tb_data_eeprom_access_control.sv ====
// Self-checking testbench for the data EEPROM access control block
`timescale 1ns/1ps
module tb_data_eeprom_access_control;
	import deac_pkg::*;

	// ==========================================================
	// Clock, reset and stimulus signals
	localparam int WCNT = 5;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] mem_ptr = CTRL_ADDR;
	logic [7:0] bank_ptr = CTRL_BANK;
	logic ind_wr = 1'b0;
	logic [7:0] ind_wdata = 8'h00;
	logic [7:0] ind_rdata;
	logic addr_wr = 1'b0;
	logic data_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] eeprom_address;
	logic [7:0] eeprom_data;
	logic low_power = 1'b0;
	logic req_clr = 1'b0;
	logic mf_ack = 1'b0;
	logic req_flag;
	logic mf_flag;
	logic busy;
	int miscompares = 0;
	int check_count = 0;
	// Start requests written without their enables
	logic [7:0] bad_starts [3] = '{8'h01, 8'h04, 8'h05};

	// Clock at 250 MHz
	always #2 sys_clk = ~sys_clk;

	deac_access_ctrl #(.WRITE_COUNT(WCNT)) dut
	(
		.sys_clk_i(sys_clk),
		.rstn_i(rstn),
		.mem_ptr_i(mem_ptr),
		.bank_ptr_i(bank_ptr),
		.ind_wr_i(ind_wr),
		.ind_wdata_i(ind_wdata),
		.ind_rdata_o(ind_rdata),
		.addr_wr_i(addr_wr),
		.data_wr_i(data_wr),
		.sfr_wdata_i(sfr_wdata),
		.eeprom_address_o(eeprom_address),
		.eeprom_data_o(eeprom_data),
		.low_power_i(low_power),
		.req_flag_clr_i(req_clr),
		.mf_flag_ack_i(mf_ack),
		.eeprom_request_flag_o(req_flag),
		.mf_request_flag_o(mf_flag),
		.busy_o(busy)
	);

	// ==========================================================
	// Comparison, verdict and bus tasks
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One write through the indirect access register, held for one edge
	task automatic ctrl_wr(input logic [7:0] v);
		@(posedge sys_clk);
		ind_wdata <= v;
		ind_wr <= 1'b1;
		@(posedge sys_clk);
		ind_wr <= 1'b0;
	endtask

	// Settle the registered control view, then compare it
	task automatic view(input logic [7:0] exp);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("control view", ind_rdata, exp);
	endtask

	// Load the address register (sel 0) or the data register (sel 1)
	task automatic sfr_wr(input logic sel, input logic [7:0] v);
		@(posedge sys_clk);
		sfr_wdata <= v;
		addr_wr <= ~sel;
		data_wr <= sel;
		@(posedge sys_clk);
		addr_wr <= 1'b0;
		data_wr <= 1'b0;
	endtask

	// Start a cycle and measure how many cycles it stays busy
	task automatic run_cycle(input logic [7:0] v, input int cycles);
		int n;
		ctrl_wr(v);
		#1;
		n = 0;
		while (busy === 1'b1 && n < 100)
		begin
			n++;
			@(posedge sys_clk);
			#1;
		end
		chk("cycle length", 8'(n), 8'(cycles));
	endtask

	// Pulse the multi-function acknowledge (sel 0) or request clear (sel 1)
	task automatic flag_clr(input logic sel);
		@(posedge sys_clk);
		mf_ack <= ~sel;
		req_clr <= sel;
		@(posedge sys_clk);
		mf_ack <= 1'b0;
		req_clr <= 1'b0;
		#1;
	endtask

	// Control write with a wrong pointer or bank, which must be ignored
	task automatic blocked_wr(input logic [7:0] ptr, input logic [7:0] bank);
		@(posedge sys_clk);
		mem_ptr <= ptr;
		bank_ptr <= bank;
		ctrl_wr(8'h02);
		@(posedge sys_clk);
		mem_ptr <= CTRL_ADDR;
		bank_ptr <= CTRL_BANK;
		view(8'h00);
	endtask

	// Watchdog: the tests need well under a thousand cycles
	initial
	begin
		#40000;
		miscompares++;
		conclude();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		view(8'h00);
		chk("flags and busy", {5'h00, req_flag, mf_flag, busy}, 8'h00);
		blocked_wr(8'h40, 8'h00);
		blocked_wr(8'h41, 8'h01);
		// Starts without their enables are ignored
		foreach (bad_starts[i])
		begin
			ctrl_wr(bad_starts[i]);
			view(8'h00);
			chk("busy", {7'h00, busy}, 8'h00);
		end
		// Write a5 to address 3c
		sfr_wr(1'b0, 8'h3c);
		sfr_wr(1'b1, 8'ha5);
		#1;
		chk("address", eeprom_address, 8'h3c);
		chk("data", eeprom_data, 8'ha5);
		// Enable and start go in consecutive writes, one idle cycle apart
		ctrl_wr(8'h08);
		run_cycle(8'h0c, WCNT);
		view(8'h08);
		chk("flags", {6'h00, req_flag, mf_flag}, 8'h03);
		flag_clr(1'b0);
		chk("flags", {6'h00, req_flag, mf_flag}, 8'h02);
		flag_clr(1'b1);
		chk("flags", {6'h00, req_flag, mf_flag}, 8'h00);
		ctrl_wr(8'h00);
		view(8'h00);
		// Read back the same location
		sfr_wr(1'b1, 8'h00);
		ctrl_wr(8'h02);
		run_cycle(8'h03, READ_CYCLES);
		chk("read data", eeprom_data, 8'ha5);
		view(8'h02);
		flag_clr(1'b0);
		flag_clr(1'b1);
		// Both starts in one write are refused
		ctrl_wr(8'h0a);
		ctrl_wr(8'h0f);
		view(8'h0a);
		chk("busy", {7'h00, busy}, 8'h00);
		// With bank 0 selected the set enables must stay hidden
		@(posedge sys_clk);
		bank_ptr <= 8'h00;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("hidden view", ind_rdata, 8'h00);
		@(posedge sys_clk);
		bank_ptr <= CTRL_BANK;
		// Write aborted by low power leaves the array and flags alone
		sfr_wr(1'b1, 8'h5a);
		ctrl_wr(8'h08);
		ctrl_wr(8'h0c);
		@(posedge sys_clk);
		low_power <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		low_power <= 1'b0;
		view(8'h08);
		chk("flags and busy", {5'h00, req_flag, mf_flag, busy}, 8'h00);
		ctrl_wr(8'h02);
		run_cycle(8'h03, READ_CYCLES);
		chk("read data", eeprom_data, 8'ha5);
		ctrl_wr(8'h00);
		view(8'h00);
		conclude();
	end

endmodule // tb_data_eeprom_access_control
